// ### logic/sdo_defs.svh
// constants for the servo digital output control block
`ifndef SDO_DEFS_SVH
`define SDO_DEFS_SVH
`define SDO_SETUP_OFFSET   16'h3724
`define SDO_BRAKE_BIT      0
`define SDO_OUT1_BIT       16
`define SDO_SETUP_INIT_BIT 0
`define SDO_SETUP_RESET    16'h0000
`define SDO_WORD_RESET     32'h0000_0000
`endif

// ### logic/sdo_pkg.sv
// types for the servo digital output control block
package sdo_pkg;
    // communication state of the fieldbus state machine
    typedef enum logic [3:0] {
        SDO_ESM_INIT   = 4'b0001,
        SDO_ESM_PREOP  = 4'b0010,
        SDO_ESM_SAFEOP = 4'b0100,
        SDO_ESM_OP     = 4'b1000
    } sdo_esm_t;
    // output follow state
    typedef enum logic [2:0] {
        SDO_ST_IDLE   = 3'b001,
        SDO_ST_FOLLOW = 3'b010,
        SDO_ST_CUT    = 3'b100
    } sdo_state_t;
endpackage

// ### logic/sdo_output_ctrl.sv
// output control for brake and general output one
//
// How it works
// - value bit 0 set engages brake, cleared releases it.
// - value bit 16 set turns general output on, cleared off.
// - mask bit 0 enables brake output.
// - mask bit 16 enables general output.
// - masked-off general output is driven zero, except it holds on interception with setup bit 0 cleared.
// - setup bit 0 cleared holds output on interception, set clears it.
// - pre-operational or higher is established; brake follows value only if masked in.
// - leaving operational or returning to init intercepts; brake forced engaged.
// - after interception, follow resumes only on a value or mask write.
`timescale 1ns/1ps
`include "sdo_defs.svh"

module sdo_output_ctrl (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire sdo_pkg::sdo_esm_t esm_state,
    input  wire logic             value_wr,
    input  wire logic [31:0]      value_wdata,
    input  wire logic             mask_wr,
    input  wire logic [31:0]      mask_wdata,
    input  wire logic             setup_wr,
    input  wire logic [15:0]      setup_wdata,
    output logic [31:0]           value_rdata,
    output logic [31:0]           mask_rdata,
    output logic [15:0]           setup_rdata,
    output logic                  comm_established,
    output logic                  comm_intercepted,
    output logic                  brake_engage,
    output logic                  general_output_one
);

    ////////////////////////////////////////////////////////////////////////////////
    // registers written by the master
    logic [31:0]         value_q;
    logic [31:0]         value_d;
    logic [31:0]         mask_q;
    logic [31:0]         mask_d;
    logic [15:0]         setup_q;
    logic [15:0]         setup_d;
    sdo_pkg::sdo_esm_t   esm_q;
    sdo_pkg::sdo_esm_t   esm_d;
    sdo_pkg::sdo_state_t st_q;
    sdo_pkg::sdo_state_t st_d;
    logic                brake_q;
    logic                brake_d;
    logic                out1_q;
    logic                out1_d;
    logic                est_flag_q;
    logic                est_flag_d;
    logic                cut_flag_q;
    logic                cut_flag_d;
    logic                est;
    logic                was_op;
    logic                cut_ev;
    logic                word_wr;

    // every write is stored whatever the communication state, so words sent before communication
    // is first up after reset take effect the moment it is established
    sdo_word_reg #(
        .WIDTH (32),
        .RESET (`SDO_WORD_RESET)
    ) i_value_reg (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .wr      (value_wr),
        .wdata   (value_wdata),
        .word_d  (value_d),
        .word_q  (value_q)
    );

    sdo_word_reg #(
        .WIDTH (32),
        .RESET (`SDO_WORD_RESET)
    ) i_mask_reg (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .wr      (mask_wr),
        .wdata   (mask_wdata),
        .word_d  (mask_d),
        .word_q  (mask_q)
    );

    sdo_word_reg #(
        .WIDTH (16),
        .RESET (`SDO_SETUP_RESET)
    ) i_setup_reg (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .wr      (setup_wr),
        .wdata   (setup_wdata),
        .word_d  (setup_d),
        .word_q  (setup_q)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // communication state tracking
    assign est     = (esm_state != sdo_pkg::SDO_ESM_INIT);
    assign was_op  = (esm_q == sdo_pkg::SDO_ESM_OP);
    // leaving op drops process data, dropping to init drops service data
    assign cut_ev  = (was_op && esm_state != sdo_pkg::SDO_ESM_OP)
                   || (esm_q != sdo_pkg::SDO_ESM_INIT
                       && esm_state == sdo_pkg::SDO_ESM_INIT);
    assign word_wr = value_wr || mask_wr;

    always_comb begin
        st_d  = st_q;
        esm_d = esm_state;
        case (st_q)
            sdo_pkg::SDO_ST_IDLE: begin
                if (est) begin
                    st_d = sdo_pkg::SDO_ST_FOLLOW;
                end
            end
            sdo_pkg::SDO_ST_FOLLOW: begin
                if (cut_ev) begin
                    st_d = sdo_pkg::SDO_ST_CUT;
                end
            end
            sdo_pkg::SDO_ST_CUT: begin
                // interception wins over a write in the same cycle
                if (word_wr && !cut_ev && est) begin
                    st_d = sdo_pkg::SDO_ST_FOLLOW;
                end
            end
            default: st_d = sdo_pkg::SDO_ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output drive, computed from the next-state view so outputs track in one cycle
    // the brake is the safe state: every path that does not follow the words engages it
    always_comb begin
        brake_d    = 1'b1;
        out1_d     = 1'b0;
        est_flag_d = 1'b0;
        cut_flag_d = 1'b0;
        case (st_d)
            sdo_pkg::SDO_ST_FOLLOW: begin
                brake_d = mask_d[`SDO_BRAKE_BIT] ? value_d[`SDO_BRAKE_BIT] : 1'b1;
                out1_d  = mask_d[`SDO_OUT1_BIT] & value_d[`SDO_OUT1_BIT];
                est_flag_d = 1'b1;
            end
            sdo_pkg::SDO_ST_CUT: begin
                // setup is read in its next-value view so a write lands with the hold choice
                brake_d    = 1'b1;
                cut_flag_d = 1'b1;
                out1_d  = setup_d[`SDO_SETUP_INIT_BIT] ? 1'b0 : out1_q;
            end
            default: begin
                brake_d = 1'b1;
                out1_d  = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            esm_q <= sdo_pkg::SDO_ESM_INIT;
            st_q  <= sdo_pkg::SDO_ST_IDLE;
        end else begin
            esm_q <= esm_d;
            st_q  <= st_d;
        end
    end

    // drive registers; out of reset the brake is engaged and the output is off
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            brake_q    <= 1'b1;
            out1_q     <= 1'b0;
            est_flag_q <= 1'b0;
            cut_flag_q <= 1'b0;
        end else begin
            brake_q    <= brake_d;
            out1_q     <= out1_d;
            est_flag_q <= est_flag_d;
            cut_flag_q <= cut_flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    assign value_rdata        = value_q;
    assign mask_rdata         = mask_q;
    assign setup_rdata        = setup_q;
    assign comm_established   = est_flag_q;
    assign comm_intercepted   = cut_flag_q;
    assign brake_engage       = brake_q;
    assign general_output_one = out1_q;

endmodule // sdo_output_ctrl

////////////////////////////////////////////////////////////////////////////////
// one word written by the master: a write strobe loads it, otherwise it holds
module sdo_word_reg #(
    parameter int               WIDTH = 32,
    parameter logic [WIDTH-1:0] RESET = '0
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             wr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] word_d,
    output logic      [WIDTH-1:0] word_q
);

    always_comb begin
        word_d = wr ? wdata : word_q;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            word_q <= RESET;
        end else begin
            word_q <= word_d;
        end
    end

endmodule // sdo_word_reg

// ### bench/sdo_output_ctrl_monitor.sv
// port checker for the servo output control block
`timescale 1ns/1ps
module sdo_mon (
    input logic              clk_sys,
    input logic              rst_b,
    input sdo_pkg::sdo_esm_t esm_state,
    input logic              value_wr,
    input logic              mask_wr,
    input logic [31:0]       value_rdata,
    input logic [31:0]       mask_rdata,
    input logic [15:0]       setup_rdata,
    input logic              comm_established,
    input logic              comm_intercepted,
    input logic              brake_engage,
    input logic              general_output_one
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_op_left;
        comm_established && esm_state == sdo_pkg::SDO_ESM_OP ##1 esm_state != sdo_pkg::SDO_ESM_OP;
    endsequence
    AST_BRK: assert property (comm_established |->
        brake_engage == (!mask_rdata[0] || value_rdata[0])) else $error("brake");
    AST_OUT: assert property (comm_established |->
        general_output_one == (mask_rdata[16] && value_rdata[16])) else $error("out");
    AST_CUT_BRK: assert property (comm_intercepted |-> brake_engage) else $error("cut");
    AST_CUT_CLR: assert property (comm_intercepted && setup_rdata[0] |->
        !general_output_one) else $error("clear");
    AST_CUT_HOLD: assert property (comm_intercepted && !setup_rdata[0] |->
        $stable(general_output_one)) else $error("hold");
    AST_IDLE: assert property (!comm_established && !comm_intercepted |->
        brake_engage && !general_output_one) else $error("idle");
    AST_LEFT_OP: assert property (s_op_left |=> comm_intercepted) else $error("op");
    AST_TO_INIT: assert property (comm_established && esm_state == sdo_pkg::SDO_ESM_INIT
        |=> comm_intercepted) else $error("init");
    AST_STAY: assert property (comm_intercepted && (esm_state == sdo_pkg::SDO_ESM_INIT
        || !(value_wr || mask_wr)) |=> comm_intercepted) else $error("stay");
    AST_RESUME: assert property (comm_intercepted && (value_wr || mask_wr)
        && esm_state != sdo_pkg::SDO_ESM_INIT && esm_state == $past(esm_state)
        |=> comm_established) else $error("resume");
endmodule // sdo_mon
bind sdo_output_ctrl sdo_mon i_mon (
    .clk_sys            (clk_sys),
    .rst_b              (rst_b),
    .esm_state          (esm_state),
    .value_wr           (value_wr),
    .mask_wr            (mask_wr),
    .value_rdata        (value_rdata),
    .mask_rdata         (mask_rdata),
    .setup_rdata        (setup_rdata),
    .comm_established   (comm_established),
    .comm_intercepted   (comm_intercepted),
    .brake_engage       (brake_engage),
    .general_output_one (general_output_one)
);

// ### bench/sdo_master_model.sv
// fieldbus master model writing the output words
`timescale 1ns/1ps
module sdo_master (
    input  logic        clk_sys,
    output logic        value_wr,
    output logic [31:0] value_wdata,
    output logic        mask_wr,
    output logic [31:0] mask_wdata,
    output logic        setup_wr,
    output logic [15:0] setup_wdata
);
    initial {value_wr, mask_wr, setup_wr, value_wdata, mask_wdata, setup_wdata} = '0;
    // k: bit0 value, bit1 mask, bit2 setup; one cyclic write, data scrambled after
    task automatic wr(input logic [2:0] k, input logic [31:0] v, input logic [31:0] m);
        @(negedge clk_sys);
        {setup_wr, mask_wr, value_wr} = k;
        {value_wdata, mask_wdata, setup_wdata} = {v, m, m[15:0]};
        @(negedge clk_sys);
        {setup_wr, mask_wr, value_wr} = 3'h0;
        {value_wdata, mask_wdata, setup_wdata} = ~{v, m, m[15:0]};
    endtask
endmodule // sdo_master

// ### bench/test_servo_digital_output_control.sv
// self-checking bench for the servo output control block
`timescale 1ns/1ps
module test_servo_digital_output_control;
    logic              clk_sys, rst_b, value_wr, mask_wr, setup_wr;
    logic              comm_established, comm_intercepted, brake_engage, general_output_one;
    logic [31:0]       value_wdata, mask_wdata, value_rdata, mask_rdata;
    logic [15:0]       setup_wdata, setup_rdata;
    sdo_pkg::sdo_esm_t esm_state;
    int                n_errors = 0, total_checks = 0;
    wire [3:0] fl = {comm_established, comm_intercepted, brake_engage, general_output_one};
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    sdo_master i_m (
        .clk_sys     (clk_sys),
        .value_wr    (value_wr),
        .value_wdata (value_wdata),
        .mask_wr     (mask_wr),
        .mask_wdata  (mask_wdata),
        .setup_wr    (setup_wr),
        .setup_wdata (setup_wdata)
    );
    sdo_output_ctrl i_dut (
        .clk_sys            (clk_sys),
        .rst_b              (rst_b),
        .esm_state          (esm_state),
        .value_wr           (value_wr),
        .value_wdata        (value_wdata),
        .mask_wr            (mask_wr),
        .mask_wdata         (mask_wdata),
        .setup_wr           (setup_wr),
        .setup_wdata        (setup_wdata),
        .value_rdata        (value_rdata),
        .mask_rdata         (mask_rdata),
        .setup_rdata        (setup_rdata),
        .comm_established   (comm_established),
        .comm_intercepted   (comm_intercepted),
        .brake_engage       (brake_engage),
        .general_output_one (general_output_one)
    );
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic st(input sdo_pkg::sdo_esm_t s);
        @(negedge clk_sys);
        esm_state = s;
        @(negedge clk_sys);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        esm_state = sdo_pkg::SDO_ESM_INIT;
        repeat (16) @(negedge clk_sys);
        rst_b = 1'b1;
        chk(fl, 4'h2);
        i_m.wr(3'h3, 32'h0001_0000, 32'h0001_0001);
        chk(value_rdata, 32'h0001_0000);
        chk(mask_rdata, 32'h0001_0001);
        chk(fl, 4'h2);
        st(sdo_pkg::SDO_ESM_PREOP);
        chk(fl, 4'h9);
        i_m.wr(3'h2, 32'h0000_0000, 32'h0000_0000);
        chk(fl, 4'ha);
        i_m.wr(3'h3, 32'h0001_0001, 32'h0001_0001);
        chk(fl, 4'hb);
        st(sdo_pkg::SDO_ESM_OP);
        st(sdo_pkg::SDO_ESM_SAFEOP);
        chk(fl, 4'h7);
        i_m.wr(3'h1, 32'h0001_0000, 32'h0000_0000);
        chk(fl, 4'h9);
        i_m.wr(3'h4, 32'h0000_0000, 32'h0000_0001);
        chk(setup_rdata, 16'h0001);
        st(sdo_pkg::SDO_ESM_INIT);
        chk(fl, 4'h6);
        i_m.wr(3'h1, 32'h0001_0001, 32'h0000_0000);
        chk(fl, 4'h6);
        st(sdo_pkg::SDO_ESM_PREOP);
        chk(fl, 4'h6);
        i_m.wr(3'h2, 32'h0000_0000, 32'h0001_0001);
        chk(fl, 4'hb);
        st(sdo_pkg::SDO_ESM_SAFEOP);
        chk(fl, 4'hb);
        @(negedge clk_sys);
        rst_b = 1'b0;
        @(negedge clk_sys);
        chk(fl, 4'h2);
        chk(value_rdata, 32'h0000_0000);
        rst_b = 1'b1;
        @(negedge clk_sys);
        chk(fl, 4'ha);
        results();
    end
endmodule // test_servo_digital_output_control
